// ==== src/sec_control.sv ====
// sequence external-control front end: state, step and branch control
module sec_control
    import sec_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // configuration
    input  wire logic              external_control_enable,
    input  wire logic              levelBranchOnConnector,
    input  wire logic              dcOutput,
    // connector and trigger pins
    input  wire logic              startPin,
    input  wire logic              stopPin,
    input  wire logic              holdPin,
    input  wire logic              eventPin,
    input  wire logic              levelPin,
    input  wire logic              trigPin,
    // current step parameters from the step engine
    input  wire logic              event_jump_enable,
    input  wire logic              level_jump_enable,
    input  wire logic [STEP_W-1:0] eventDest,
    input  wire logic [STEP_W-1:0] levelDest,
    input  wire logic [TIME_W-1:0] stepTime,
    input  wire logic              stepAdvance,
    input  wire logic [STEP_W-1:0] nextStep,
    input  wire logic              seqEnd,
    // store request
    input  wire logic              storeReq,
    input  wire logic [SLOT_W-1:0] storeSlot,
    input  wire logic              storeToUsb,
    input  wire logic              usbHostBusy,
    // status
    output logic [1:0]             seqState,
    output logic [STEP_W-1:0]      curStep,
    output logic                   outputFrozen,
    output logic                   storeGo,
    output logic [SLOT_W-1:0]      storeSlotOut,
    output logic                   storeRefused
);
    sec_sync_if startSync ();
    sec_sync_if stopSync ();
    sec_sync_if holdSync ();
    sec_sync_if eventSync ();
    sec_sync_if levelSync ();
    sec_sync_if trigSync ();

    sec_state_type              stateReg;
    logic [STEP_W-1:0]          stepReg;
    logic [TIME_W-1:0]          elapsedReg;
    logic                       startPendReg;
    logic                       trigPendReg;
    logic                       stopPendReg;
    logic                       eventPendReg;
    logic [LAT_W-1:0]           latCntReg;
    logic [LAT_W-1:0]           trigCntReg;
    logic                       frozenReg;
    logic                       storeGoReg;
    logic [SLOT_W-1:0]          storeSlotReg;
    logic                       storeRefusedReg;
    logic                       connOk;
    logic                       timeDone;
    logic [LAT_W-1:0]           trigTarget;

    // ======================================================================
    // input synchronisers
    sec_sync_edge uStart (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pinIn   (startPin),
        .syncOut (startSync)
    );
    sec_sync_edge uStop (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pinIn   (stopPin),
        .syncOut (stopSync)
    );
    sec_sync_edge uHold (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pinIn   (holdPin),
        .syncOut (holdSync)
    );
    sec_sync_edge uEvent (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pinIn   (eventPin),
        .syncOut (eventSync)
    );
    sec_sync_edge uLevel (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pinIn   (levelPin),
        .syncOut (levelSync)
    );
    sec_sync_edge uTrig (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pinIn   (trigPin),
        .syncOut (trigSync)
    );

    // ======================================================================
    // gating of connector inputs
    assign connOk     = external_control_enable;
    assign timeDone   = (elapsedReg >= stepTime);
    assign trigTarget = dcOutput ? LAT_W'(TRIG_DC_CYC) : LAT_W'(TRIG_WAVE_CYC);

    // ======================================================================
    // connector start, stop and event wait a fixed latency before acting; start disabled
    // on connector when level branching owns it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            startPendReg <= 1'b0;
            stopPendReg  <= 1'b0;
            eventPendReg <= 1'b0;
            latCntReg    <= '0;
        end else if (!connOk || stateReg == SEC_READY && stopPendReg) begin
            startPendReg <= 1'b0;
            stopPendReg  <= 1'b0;
            eventPendReg <= 1'b0;
            latCntReg    <= '0;
        end else if (startPendReg || stopPendReg || eventPendReg) begin
            if (latCntReg == LAT_W'(CONN_LAT_CYC - 1)) begin
                startPendReg <= 1'b0;
                stopPendReg  <= 1'b0;
                eventPendReg <= 1'b0;
                latCntReg    <= '0;
            end else begin
                latCntReg <= latCntReg + 1'b1;
            end
        end else begin
            // start only from ready; start blocked when level uses connector
            startPendReg <= startSync.fall && stateReg == SEC_READY && !levelBranchOnConnector;
            stopPendReg  <= stopSync.fall && stateReg != SEC_READY;
            eventPendReg <= eventSync.fall && stateReg != SEC_READY && event_jump_enable;
        end
    end

    // ======================================================================
    // trigger start: own latency, start only
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            trigPendReg <= 1'b0;
            trigCntReg  <= '0;
        end else if (trigPendReg) begin
            if (trigCntReg == trigTarget - 1'b1) begin
                trigPendReg <= 1'b0;
                trigCntReg  <= '0;
            end else begin
                trigCntReg <= trigCntReg + 1'b1;
            end
        end else begin
            trigPendReg <= trigSync.fall && stateReg == SEC_READY;
        end
    end

    // ======================================================================
    // state and step
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stateReg   <= SEC_READY;
            stepReg    <= STEP_ZERO;
            elapsedReg <= '0;
        end else begin
            case (stateReg)
                SEC_READY: begin
                    stepReg    <= STEP_ZERO;
                    elapsedReg <= '0;
                    if ((startPendReg && latCntReg == LAT_W'(CONN_LAT_CYC - 1)) ||
                        (trigPendReg && trigCntReg == trigTarget - 1'b1)) begin
                        stateReg <= SEC_RUN;
                    end
                end
                SEC_RUN, SEC_HOLD: begin
                    if (stopPendReg && latCntReg == LAT_W'(CONN_LAT_CYC - 1)) begin
                        stateReg <= SEC_READY;
                        stepReg  <= STEP_ZERO;
                    end else if (eventPendReg && latCntReg == LAT_W'(CONN_LAT_CYC - 1)) begin
                        stepReg    <= eventDest;
                        elapsedReg <= '0;
                    end else if (connOk && level_jump_enable && timeDone && !levelSync.level) begin
                        stepReg    <= levelDest;
                        elapsedReg <= '0;
                    end else if (stateReg == SEC_RUN && connOk && holdSync.fall) begin
                        stateReg <= SEC_HOLD;
                    end else if (stateReg == SEC_HOLD && connOk && holdSync.rise) begin
                        stateReg <= SEC_RUN;
                    end else if (stateReg == SEC_RUN && seqEnd) begin
                        stateReg <= SEC_READY;
                        stepReg  <= STEP_ZERO;
                    end else if (stateReg == SEC_RUN && stepAdvance) begin
                        stepReg    <= nextStep;
                        elapsedReg <= '0;
                    end else if (stateReg == SEC_RUN && !timeDone) begin
                        elapsedReg <= elapsedReg + 1'b1;  // frozen while held
                    end
                end
                default: stateReg <= SEC_READY;
            endcase
        end
    end

    // ======================================================================
    // hold freezes outputs; store handshake with USB refusal
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            frozenReg       <= 1'b0;
            storeGoReg      <= 1'b0;
            storeSlotReg    <= SLOT_MIN;
            storeRefusedReg <= 1'b0;
        end else begin
            frozenReg  <= (stateReg == SEC_HOLD);
            storeGoReg <= 1'b0;
            storeRefusedReg <= 1'b0;
            if (storeReq) begin
                if (storeToUsb && usbHostBusy) begin
                    storeRefusedReg <= 1'b1;
                end else if (!storeToUsb && (storeSlot < SLOT_MIN || storeSlot > SLOT_MAX)) begin
                    storeRefusedReg <= 1'b1;
                end else begin
                    storeGoReg   <= 1'b1;
                    storeSlotReg <= storeSlot;
                end
            end
        end
    end

    // outputs straight from flip-flops
    assign seqState     = stateReg;
    assign curStep      = stepReg;
    assign outputFrozen = frozenReg;
    assign storeGo      = storeGoReg;
    assign storeSlotOut = storeSlotReg;
    assign storeRefused = storeRefusedReg;
endmodule // sec_control

// ==== src/sec_pkg.sv ====
// constants and types for the sequence external-control front end
// ==========================================================================
// ==========================================================================
package sec_pkg;
    // ======================================================================
    // sizes
    localparam int STEP_W  = 8;
    localparam int SLOT_W  = 4;
    localparam int TIME_W  = 24;
    localparam logic [STEP_W-1:0] STEP_ZERO = 8'h00;
    localparam logic [SLOT_W-1:0] SLOT_MIN  = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_MAX  = 4'hA;
    // ======================================================================
    // timing
    localparam int CLK_HZ          = 25000000;
    localparam int CONN_LAT_NS     = 200000;  // least connector latency
    localparam int TRIG_WAVE_NS    = 15000;
    localparam int TRIG_DC_NS      = 18000;
    localparam int CONN_LAT_CYC    = (CONN_LAT_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int TRIG_WAVE_CYC   = (TRIG_WAVE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int TRIG_DC_CYC     = (TRIG_DC_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int LAT_W           = 13;
    // ======================================================================
    // sequencer states
    typedef enum logic [1:0] {
        SEC_READY,
        SEC_RUN,
        SEC_HOLD
    } sec_state_type;
endpackage : sec_pkg

// ==== src/sec_sync_edge.sv ====
// three-stage synchroniser with edge detection for one pin
module sec_sync_edge (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // pin and result
    input  wire logic pinIn,
    sec_sync_if.src   syncOut
);
    logic s1Reg;
    logic s2Reg;
    logic s3Reg;
    logic stableReg;

    // ======================================================================
    // first stage feeds only the second; idle level is high (inputs pulled up)
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1Reg     <= 1'b1;
            s2Reg     <= 1'b1;
            s3Reg     <= 1'b1;
            stableReg <= 1'b1;
        end else begin
            s1Reg <= pinIn;
            s2Reg <= s1Reg;
            s3Reg <= s2Reg;
            if (s2Reg == s3Reg) begin
                stableReg <= s3Reg;
            end
        end
    end

    // one pulse per accepted change
    assign syncOut.level = stableReg;
    assign syncOut.fall  = stableReg & (s2Reg == s3Reg) & ~s3Reg;
    assign syncOut.rise  = ~stableReg & (s2Reg == s3Reg) & s3Reg;
endmodule // sec_sync_edge

// ==== src/sec_sync_if.sv ====
// interface carrying one synchronised input and its edges
interface sec_sync_if;
    logic level;
    logic fall;
    logic rise;
    modport src (output level, output fall, output rise);
    modport dst (input level, input fall, input rise);
endinterface : sec_sync_if

// ==== tb/sec_control_checker.sv ====
// assertion checker for the sequence external-control front end
module sec_control_checker
    import sec_pkg::*;
(
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              sys_rst,
    // store request
    input wire logic              storeReq,
    input wire logic [SLOT_W-1:0] storeSlot,
    input wire logic              storeToUsb,
    input wire logic              usbHostBusy,
    // status
    input wire logic [1:0]        seqState,
    input wire logic [STEP_W-1:0] curStep,
    input wire logic              outputFrozen,
    input wire logic              storeGo,
    input wire logic [SLOT_W-1:0] storeSlotOut,
    input wire logic              storeRefused
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // slot legality, usb conflict refuses even a legal slot
    wire slotOk = storeSlot >= SLOT_MIN && storeSlot <= SLOT_MAX;
    a_reset_ready: assert property ($fell(sys_rst) |-> seqState == 2'h0 && curStep == 8'h00) else $error("bad reset");
    a_hold_frozen: assert property (seqState == 2'h2 |=> outputFrozen) else $error("hold not frozen");
    a_frozen_cause: assert property (outputFrozen |-> $past(seqState) == 2'h2) else $error("frozen out of hold");
    a_ready_no_hold: assert property ($past(seqState) == 2'h0 |-> seqState != 2'h2) else $error("ready to hold");
    a_stop_zero: assert property (seqState == 2'h0 && $past(seqState) != 2'h0 |-> curStep == 8'h00)
        else $error("stop step");
    a_slot_refuse: assert property (storeReq && !storeToUsb && !slotOk |=> storeRefused && !storeGo)
        else $error("bad slot");
    a_usb_refuse: assert property (storeReq && storeToUsb && usbHostBusy |=> storeRefused && !storeGo)
        else $error("usb");
    a_store_copy: assert property (storeReq && slotOk && !(storeToUsb && usbHostBusy) |=>
        storeGo && storeSlotOut == $past(storeSlot)) else $error("store lost");
endmodule // sec_control_checker
bind sec_control sec_control_checker chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .storeReq(storeReq),
    .storeSlot(storeSlot), .storeToUsb(storeToUsb), .usbHostBusy(usbHostBusy), .seqState(seqState),
    .curStep(curStep), .outputFrozen(outputFrozen), .storeGo(storeGo), .storeSlotOut(storeSlotOut),
    .storeRefused(storeRefused));

// ==== tb/sec_control_tb.sv ====
// self-checking testbench for the sequence external-control front end
module sec_control_tb
    import sec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, sys_rst = 1, en = 0, lbc = 0, dc = 0, ej = 0, lj = 0, adv = 0, sEnd = 0;
    logic req = 0, toUsb = 0, usbBusy = 0, fr, go, refused;
    logic [7:0] eDest = 8'h00, lDest = 8'h00, nStep = 8'h00, cs;
    logic [23:0] sTime = 24'h00000A;
    logic [3:0] slot = 4'h1, slotOut;
    logic [1:0] st;
    wire [5:0] pins;
    int numErrors = 0, checkCount = 0, n, lo;
    logic expGo;
    initial forever #20 ref_clk = ~ref_clk;
    sec_ext_logic pm (.ref_clk(ref_clk), .pins(pins));
    sec_control uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .external_control_enable(en),
        .levelBranchOnConnector(lbc), .dcOutput(dc), .startPin(pins[0]), .stopPin(pins[1]), .holdPin(pins[2]),
        .eventPin(pins[3]), .levelPin(pins[4]), .trigPin(pins[5]), .event_jump_enable(ej),
        .level_jump_enable(lj), .eventDest(eDest), .levelDest(lDest), .stepTime(sTime), .stepAdvance(adv),
        .nextStep(nStep), .seqEnd(sEnd), .storeReq(req), .storeSlot(slot), .storeToUsb(toUsb),
        .usbHostBusy(usbBusy), .seqState(st), .curStep(cs), .outputFrozen(fr), .storeGo(go),
        .storeSlotOut(slotOut), .storeRefused(refused));
    // ==========================================================
    // report and shared tasks
    task automatic finishTest();
        $display("errors %0d checks %0d", numErrors, checkCount);
        if (numErrors == 0 && checkCount > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checkCount++;
        if (got !== exp) begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    // bounded wait on state (what 0) or step (what 1)
    task automatic waitFor(input int what, input logic [7:0] exp, input int maxN, output int cnt);
        cnt = 0;
        #1;
        while ((what == 1 ? cs : {6'h00, st}) !== exp && cnt < maxN) begin
            tick(1);
            cnt++;
        end
        if (cnt >= maxN) begin
            numErrors++;
            $display("wrong value wait expected %h seen timeout", exp);
            finishTest();
        end
    endtask
    task automatic stepPulse(input logic [7:0] s);
        @(posedge ref_clk);
        nStep <= s;
        adv <= 1'b1;
        @(posedge ref_clk);
        adv <= 1'b0;
        tick(1);
    endtask
    // ==========================================================
    // scenarios; latency bounds leave a few cycles for the synchroniser
    initial begin
        tick(10);
        sys_rst <= 1'b0;
        tick(1);
        check("state", 8'h00, {6'h00, st});
        check("step", 8'h00, cs);
        check("slot", 8'h01, {4'h0, slotOut});
        pm.pulse(0);
        tick(5100);
        check("state", 8'h00, {6'h00, st});
        en <= 1'b1;
        pm.pulse(0);
        waitFor(0, 8'h01, 6000, n);
        check("start delay", 8'h01, {7'h00, n > 4980});
        pm.pulse(0);
        tick(5100);
        check("state", 8'h01, {6'h00, st});
        stepPulse(8'h03);
        check("step", 8'h03, cs);
        pm.setPin(2, 1'b0);
        waitFor(0, 8'h02, 20, n);
        tick(1);
        check("frozen", 8'h01, {7'h00, fr});
        stepPulse(8'h07);
        pm.pulse(5);
        tick(500);
        check("state", 8'h02, {6'h00, st});
        check("step", 8'h03, cs);
        pm.setPin(2, 1'b1);
        waitFor(0, 8'h01, 20, n);
        check("step", 8'h03, cs);
        ej <= 1'b1;
        eDest <= 8'h2A;
        pm.pulse(3);
        waitFor(1, 8'h2A, 6000, n);
        lj <= 1'b1;
        lDest <= 8'h55;
        sTime <= 24'h000014;
        pm.setPin(4, 1'b0);
        waitFor(1, 8'h55, 100, n);
        check("level delay", 8'h01, {7'h00, n > 15});
        pm.setPin(4, 1'b1);
        lj <= 1'b0;
        pm.pulse(1);
        waitFor(0, 8'h00, 6000, n);
        check("step", 8'h00, cs);
        lbc <= 1'b1;
        pm.pulse(0);
        tick(5100);
        check("state", 8'h00, {6'h00, st});
        // both trigger latencies; first run ends from the engine, second by stop pin
        for (int d = 0; d < 2; d++) begin
            dc <= d[0];
            lo = (d == 1 ? TRIG_DC_CYC : TRIG_WAVE_CYC) - 20;
            pm.pulse(5);
            waitFor(0, 8'h01, 1000, n);
            check("trig delay", 8'h01, {7'h00, n > lo && n < lo + 30});
            if (d == 0) begin
                @(posedge ref_clk);
                sEnd <= 1'b1;
                @(posedge ref_clk);
                sEnd <= 1'b0;
                tick(1);
                check("end state", 8'h00, {6'h00, st});
                check("end step", 8'h00, cs);
            end else begin
                pm.pulse(1);
                waitFor(0, 8'h00, 6000, n);
            end
        end
        // u: 0 internal slot, 1 usb while host busy, 2 usb while host idle
        for (int s = 0; s < 12; s++) begin
            for (int u = 0; u < 3; u++) begin
                @(posedge ref_clk);
                slot <= 4'(s);
                toUsb <= (u != 0);
                usbBusy <= (u == 1);
                req <= 1'b1;
                @(posedge ref_clk);
                req <= 1'b0;
                #1;
                expGo = (u == 2) || (s >= 1 && s <= 10 && u == 0);
                check("go", {7'h00, expGo}, {7'h00, go});
                check("refused", {7'h00, !expGo}, {7'h00, refused});
                if (expGo) check("slot", {4'h0, 4'(s)}, {4'h0, slotOut});
            end
        end
        finishTest();
    end
endmodule // sec_control_tb

// ==== tb/sec_ext_logic.sv ====
// external ttl logic model driving connector and trigger pins
module sec_ext_logic (
    // clock
    input  wire logic       ref_clk,
    // pins: start stop hold event level trigger, idle high
    output logic [5:0]      pins
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pins = 6'h3F;
    // drive one pin after an edge so the sync stages never race
    task automatic setPin(input int i, input logic v);
        @(posedge ref_clk);
        pins[i] <= v;
    endtask
    // short low pulse, one fall and one rise
    task automatic pulse(input int i);
        setPin(i, 1'b0);
        repeat (8) @(posedge ref_clk);
        pins[i] <= 1'b1;
    endtask
endmodule // sec_ext_logic
